// ===== design/eda_pkg.sv
// Constants, field layout and state codes for the non-volatile byte store access block.
// Assumes the processor core drives a byte-wide special function register port on i_mclk.
//
// Contract
// - Store holds thirty-two bytes, selected by a five-bit address.
// - Each access moves one byte; address and data in bank 0, control in bank 1.
// - Control sits at 40H of bank 1, reached indirectly with bank select 01H.
// - Address register: five read/write bits, reset zero, upper three read zero.
// - Data register: eight read/write bits, cleared at reset.
// - Control bits: write permit 3, write trigger 2, read permit 1, read trigger 0.
// - Write trigger starts a cycle only if write permit was already high.
// - Hardware clears write trigger when the write cycle completes.
// - Read trigger starts a cycle only if read permit was already high.
// - Hardware clears read trigger at read end; fetched byte sits in data register.
// - Data register keeps fetched byte until a later read or write.
// - No store write happens while write permit is low.
// - Write cycle length is timed from the asynchronous low speed clock.
// - Write end sets store flag; enabled request vectors; service clears flag and global.
// - Reset clears write permit.
// - Bank select bit chooses bank 0 or 1 and resets to bank 0.
package eda_pkg;

  // Register port
  localparam int SFR_AW = 8;
  localparam logic [7:0] SECOND_INDIRECT_PORT_OFS = 8'h02;
  localparam logic [7:0] MP1_OFS = 8'h03;
  localparam logic [7:0] BANK_OFS = 8'h04;
  localparam logic [7:0] IRQ_OFS = 8'h0E;
  localparam logic [7:0] ADDR_OFS = 8'h1A;
  localparam logic [7:0] DATA_OFS = 8'h1B;
  localparam logic [7:0] CTRL_OFS = 8'h40;
  localparam logic CTRL_BANK = 1'b1;

  // Store geometry
  localparam int ADDR_W = 5;
  localparam int STORE_DEPTH = 32;
  localparam int DATA_W = 8;

  // Control fields
  localparam int WR_PERMIT_BIT = 3;
  localparam int WR_TRIG_BIT = 2;
  localparam int RD_PERMIT_BIT = 1;
  localparam int RD_TRIG_BIT = 0;

  // Interrupt control fields
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_FLAG_BIT = 1;
  localparam int IRQ_GLOBAL_BIT = 2;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [ADDR_W-1:0] RST_ADDR = 5'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int READ_CYCLE_NS = 100;
  localparam logic [2:0] READ_CYCLE_CLKS =
    3'((READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WR_CYCLE_LSC_TICKS = 8'h40;

  typedef enum logic [2:0] {
    EDA_IDLE = 3'b001,
    EDA_READ = 3'b010,
    EDA_WRITE = 3'b100
  } eda_state_t;

endpackage

// ===== design/eda_store.sv
// Thirty-two byte non-volatile array with registered read.
// Assumes one write and one read address per cycle; contents are not reset.
module eda_store (
  // Clock
  input wire logic i_mclk,
  // Write side
  input wire logic i_wr_en,
  input wire logic [eda_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [eda_pkg::DATA_W-1:0] i_wr_data,
  // Read side
  input wire logic [eda_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [eda_pkg::DATA_W-1:0] o_rd_data
);
  import eda_pkg::*;

  // Retains across reset, as the cells would
  logic [DATA_W-1:0] cells [STORE_DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_wr_en) begin
      cells[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    o_rd_data <= cells[i_rd_addr];
  end

endmodule

// ===== design/eda_write_timer.sv
// Self-timed write cycle length counted in low speed clock edges.
// Assumes the low speed clock level is already synchronous to i_mclk.
module eda_write_timer (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_low_speed_clock,
  output logic o_done
);
  import eda_pkg::*;

  logic running;
  logic lsc_prev;
  logic [7:0] ticks;
  logic lsc_rise;

  assign lsc_rise = i_low_speed_clock & ~lsc_prev;
  // No edges, no end: a stopped low speed clock stalls the cycle
  assign o_done = running & lsc_rise & (ticks == WR_CYCLE_LSC_TICKS - 8'h01);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lsc_prev <= 1'b0;
    end else begin
      lsc_prev <= i_low_speed_clock;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      running <= 1'b0;
      ticks <= 8'h00;
    end else if (i_start) begin
      running <= 1'b1;
      ticks <= 8'h00;
    end else if (i_abort || o_done) begin
      running <= 1'b0;
      ticks <= 8'h00;
    end else if (running && lsc_rise) begin
      ticks <= ticks + 8'h01;
    end
  end

endmodule

// ===== design/eda_nvm_access.sv
// Top of the non-volatile byte store access block: registers, cycle control, store request.
// Assumes the core's register port: one write or read strobe per cycle on i_mclk,
// direct addresses reach bank 0, the indirect port reaches bank and pointer.
module eda_nvm_access (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [eda_pkg::SFR_AW-1:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // System
  input wire logic i_low_speed_clock,
  input wire logic i_cpu_halt,
  input wire logic i_stack_full,
  input wire logic i_irq_serviced,
  output logic o_store_irq_req,
  output logic o_nvm_busy
);
  import eda_pkg::*;

  // Software visible state
  logic [ADDR_W-1:0] nvm_address;
  logic [DATA_W-1:0] nvm_data;
  logic write_permit;
  logic write_trigger;
  logic read_permit;
  logic read_trigger;
  logic bank_select_bit;
  logic [7:0] second_memory_pointer;
  logic store_irq_enable;
  logic store_irq_flag;
  logic global_irq_enable;

  // Cycle control
  eda_state_t state;
  eda_state_t next_state;
  logic [2:0] rd_cnt;
  logic [ADDR_W-1:0] op_addr;
  logic [DATA_W-1:0] op_data;
  logic [DATA_W-1:0] store_rd_data;
  logic wr_done;

  // Decode
  logic indirect;
  logic [8:0] eff_addr;
  logic sel_addr;
  logic sel_data;
  logic sel_ctrl;
  logic sel_mp1;
  logic sel_bank;
  logic sel_irq;
  logic ctrl_wr;
  logic rd_start;
  logic wr_start;
  logic rd_end;
  logic wr_end;
  logic wr_commit;
  logic [7:0] next_rdata;

  // Indirect access follows bank select; direct access always lands in bank 0
  assign indirect = (i_sfr_addr == SECOND_INDIRECT_PORT_OFS);
  assign eff_addr = indirect ? {bank_select_bit, second_memory_pointer}
                             : {1'b0, i_sfr_addr};

  assign sel_addr = (eff_addr == {1'b0, ADDR_OFS});
  assign sel_data = (eff_addr == {1'b0, DATA_OFS});
  assign sel_ctrl = (eff_addr == {CTRL_BANK, CTRL_OFS});
  assign sel_mp1 = !indirect && (i_sfr_addr == MP1_OFS);
  assign sel_bank = !indirect && (i_sfr_addr == BANK_OFS);
  assign sel_irq = (eff_addr == {1'b0, IRQ_OFS});

  assign ctrl_wr = i_sfr_wr && sel_ctrl;

  // Permit must already be set; both triggers together start nothing
  assign rd_start = (state == EDA_IDLE) && ctrl_wr && i_sfr_wdata[RD_TRIG_BIT]
                    && !i_sfr_wdata[WR_TRIG_BIT] && read_permit;
  assign wr_start = (state == EDA_IDLE) && ctrl_wr && i_sfr_wdata[WR_TRIG_BIT]
                    && !i_sfr_wdata[RD_TRIG_BIT] && write_permit;

  // A halt cuts a running cycle short and the operation is lost
  assign rd_end = (state == EDA_READ) && (i_cpu_halt || (rd_cnt == READ_CYCLE_CLKS - 3'h1));
  assign wr_end = (state == EDA_WRITE) && (i_cpu_halt || wr_done);
  assign wr_commit = (state == EDA_WRITE) && wr_done && !i_cpu_halt && write_permit;

  assign o_nvm_busy = (state != EDA_IDLE);

  eda_store u_store (
    .i_mclk(i_mclk),
    .i_wr_en(wr_commit),
    .i_wr_addr(op_addr),
    .i_wr_data(op_data),
    .i_rd_addr(op_addr),
    .o_rd_data(store_rd_data)
  );

  eda_write_timer u_timer (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_start(wr_start),
    .i_abort((state == EDA_WRITE) && i_cpu_halt),
    .i_low_speed_clock(i_low_speed_clock),
    .o_done(wr_done)
  );

  // Cycle sequencer
  always_comb begin
    next_state = state;
    case (state)
      EDA_IDLE: begin
        if (rd_start) begin
          next_state = EDA_READ;
        end else if (wr_start) begin
          next_state = EDA_WRITE;
        end
      end
      EDA_READ: begin
        if (rd_end) begin
          next_state = EDA_IDLE;
        end
      end
      EDA_WRITE: begin
        if (wr_end) begin
          next_state = EDA_IDLE;
        end
      end
      default: begin
        next_state = EDA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= EDA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Read cycle length; store read address settles on the first cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rd_cnt <= 3'h0;
    end else if (rd_start) begin
      rd_cnt <= 3'h0;
    end else if (state == EDA_READ) begin
      rd_cnt <= rd_cnt + 3'h1;
    end
  end

  // Operands latched at start so later register writes cannot corrupt a cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      op_addr <= RST_ADDR;
      op_data <= RST_BYTE;
    end else if (rd_start || wr_start) begin
      op_addr <= nvm_address;
      op_data <= nvm_data;
    end
  end

  // Address register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      nvm_address <= RST_ADDR;
    end else if (i_sfr_wr && sel_addr) begin
      nvm_address <= i_sfr_wdata[ADDR_W-1:0];
    end
  end

  // Data register; a fetch landing in the same cycle as a software write wins
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      nvm_data <= RST_BYTE;
    end else if (rd_end && !i_cpu_halt) begin
      nvm_data <= store_rd_data;
    end else if (i_sfr_wr && sel_data) begin
      nvm_data <= i_sfr_wdata;
    end
  end
  // Otherwise the fetched byte simply holds

  // Permit bits
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      write_permit <= 1'b0;
      read_permit <= 1'b0;
    end else if (ctrl_wr) begin
      write_permit <= i_sfr_wdata[WR_PERMIT_BIT];
      read_permit <= i_sfr_wdata[RD_PERMIT_BIT];
    end
  end

  // Trigger bits: set only by an accepted start, cleared only by hardware
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      write_trigger <= 1'b0;
      read_trigger <= 1'b0;
    end else begin
      if (wr_start) begin
        write_trigger <= 1'b1;
      end else if (wr_end) begin
        write_trigger <= 1'b0;
      end
      if (rd_start) begin
        read_trigger <= 1'b1;
      end else if (rd_end) begin
        read_trigger <= 1'b0;
      end
    end
  end
  // Writes to the triggers while busy change nothing

  // Bank select and pointer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bank_select_bit <= 1'b0;
      second_memory_pointer <= RST_BYTE;
    end else begin
      if (i_sfr_wr && sel_bank) begin
        bank_select_bit <= i_sfr_wdata[0];
      end
      if (i_sfr_wr && sel_mp1) begin
        second_memory_pointer <= i_sfr_wdata;
      end
    end
  end

  // Store interrupt; a finishing write beats a same-cycle clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      store_irq_flag <= 1'b0;
    end else if (state == EDA_WRITE && wr_done && !i_cpu_halt) begin
      store_irq_flag <= 1'b1;
    end else if (i_irq_serviced) begin
      store_irq_flag <= 1'b0;
    end else if (i_sfr_wr && sel_irq) begin
      store_irq_flag <= i_sfr_wdata[IRQ_FLAG_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      store_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end else begin
      if (i_sfr_wr && sel_irq) begin
        store_irq_enable <= i_sfr_wdata[IRQ_EN_BIT];
      end
      if (i_irq_serviced) begin
        global_irq_enable <= 1'b0;
      end else if (i_sfr_wr && sel_irq) begin
        global_irq_enable <= i_sfr_wdata[IRQ_GLOBAL_BIT];
      end
    end
  end

  assign o_store_irq_req = store_irq_flag && store_irq_enable
                           && global_irq_enable && !i_stack_full;

  // Read-back
  always_comb begin
    next_rdata = RST_BYTE;
    if (sel_addr) begin
      next_rdata = {3'h0, nvm_address};
    end else if (sel_data) begin
      next_rdata = nvm_data;
    end else if (sel_ctrl) begin
      next_rdata = {4'h0, write_permit, write_trigger, read_permit, read_trigger};
    end else if (sel_mp1) begin
      next_rdata = second_memory_pointer;
    end else if (sel_bank) begin
      next_rdata = {7'h00, bank_select_bit};
    end else if (sel_irq) begin
      next_rdata = {5'h00, global_irq_enable, store_irq_flag, store_irq_enable};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sfr_rdata <= RST_BYTE;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= next_rdata;
    end
  end

endmodule

// ===== verif/eda_nvm_access_asserts.sv
// Port-level checker for the store access block.
// Assumes one clock, synchronous active-high reset; bound to the top module.
module eda_nvm_access_asserts
  import eda_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [SFR_AW-1:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  // System
  input wire logic i_low_speed_clock,
  input wire logic i_cpu_halt,
  input wire logic i_stack_full,
  input wire logic i_irq_serviced,
  input wire logic o_store_irq_req,
  input wire logic o_nvm_busy
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // Cycle just started and not halted at once
  sequence s_started;
    $rose(o_nvm_busy) && !i_cpu_halt;
  endsequence
  sequence s_halted;
    i_cpu_halt && o_nvm_busy;
  endsequence

  a_reset_quiet: assert property ($fell(i_rst) |->
    o_sfr_rdata == 8'h00 && !o_nvm_busy && !o_store_irq_req)
    else $error("Outputs not cleared by reset");
  a_start_by_wr: assert property ($rose(o_nvm_busy) |->
    $past(i_sfr_wr) && $past(i_sfr_addr) == SECOND_INDIRECT_PORT_OFS)
    else $error("Cycle started without a control write");
  a_read_two_clks: assert property (s_started |=> o_nvm_busy)
    else $error("Cycle ended too early");
  a_halt_aborts: assert property (s_halted |-> ##[1:2] !o_nvm_busy)
    else $error("Halt did not end the cycle");
  a_direct_ctrl_zero: assert property (i_sfr_rd && i_sfr_addr == CTRL_OFS |=>
    o_sfr_rdata == 8'h00)
    else $error("Control reachable by direct address");
  a_addr_high_zero: assert property (i_sfr_rd && i_sfr_addr == ADDR_OFS |=>
    o_sfr_rdata[7:5] == 3'h0)
    else $error("Address upper bits not zero");
  a_rdata_holds: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("Read data moved without a read");
  a_irq_stack_gate: assert property (i_stack_full |-> !o_store_irq_req)
    else $error("Request raised with stack full");
  a_irq_serviced: assert property (i_irq_serviced |=> !o_store_irq_req)
    else $error("Request kept after service");
endmodule

bind eda_nvm_access eda_nvm_access_asserts eda_nvm_access_asserts_inst (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
  .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
  .i_low_speed_clock(i_low_speed_clock), .i_cpu_halt(i_cpu_halt),
  .i_stack_full(i_stack_full), .i_irq_serviced(i_irq_serviced),
  .o_store_irq_req(o_store_irq_req), .o_nvm_busy(o_nvm_busy));

// ===== verif/eda_nvm_access_tb.sv
// Self-checking bench for the store access block.
// Assumes package and design compiled first; bench drives all ports itself.
module eda_nvm_access_tb
  import eda_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [SFR_AW-1:0] i_sfr_addr = '0;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] o_sfr_rdata;
  logic i_low_speed_clock = 1'b0;
  logic i_cpu_halt = 1'b0;
  logic i_stack_full = 1'b0;
  logic i_irq_serviced = 1'b0;
  logic o_store_irq_req;
  logic o_nvm_busy;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [4:0] a;
  logic [7:0] d;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  eda_nvm_access eda_nvm_access_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .i_low_speed_clock(i_low_speed_clock), .i_cpu_halt(i_cpu_halt),
    .i_stack_full(i_stack_full), .i_irq_serviced(i_irq_serviced),
    .o_store_irq_req(o_store_irq_req), .o_nvm_busy(o_nvm_busy));

  initial begin
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  task automatic cmp1(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      $display("BAD %s expected %b seen %b", n, e, s);
      bad_count++;
    end
  endtask
  // Each access sets both strobes once, so back-to-back calls never double-drive
  task automatic acc(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] dt);
    i_sfr_wr = w;
    i_sfr_rd = r;
    i_sfr_addr = ad;
    i_sfr_wdata = dt;
    @(negedge i_mclk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    acc(1'b1, 1'b0, ad, dt);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, ad, 8'h00);
  endtask
  task automatic idle(input int n);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic lsc(input int n);
    repeat (n) begin
      i_low_speed_clock = ~i_low_speed_clock;
      @(negedge i_mclk);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    rd_seen <= i_sfr_rd;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end
  always @(negedge i_mclk) begin
    if (rd_seen === 1'b1) begin
      cmp8("rdata", exp_q.pop_front(), o_sfr_rdata);
    end
  end

  initial begin
    void'($urandom(32'h8C5F29C0));
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    rd(BANK_OFS, 8'h00);
    rd(ADDR_OFS, 8'h00);
    rd(DATA_OFS, 8'h00);
    rd(IRQ_OFS, 8'h00);
    rd(8'h7F, 8'h00);
    wr(MP1_OFS, 8'h40);
    rd(SECOND_INDIRECT_PORT_OFS, 8'h00);
    wr(BANK_OFS, 8'h01);
    rd(BANK_OFS, 8'h01);
    rd(SECOND_INDIRECT_PORT_OFS, 8'h00);
    rd(CTRL_OFS, 8'h00);
    wr(ADDR_OFS, 8'hFF);
    rd(ADDR_OFS, 8'h1F);
    wr(SECOND_INDIRECT_PORT_OFS, 8'hF0);
    rd(SECOND_INDIRECT_PORT_OFS, 8'h00);
    wr(SECOND_INDIRECT_PORT_OFS, 8'h01);
    wr(SECOND_INDIRECT_PORT_OFS, 8'h04);
    idle(1);
    cmp1("busy", 1'b0, o_nvm_busy);
    rd(SECOND_INDIRECT_PORT_OFS, 8'h00);
    a = 5'($urandom);
    d = 8'($urandom);
    wr(ADDR_OFS, {3'h0, a});
    wr(DATA_OFS, d);
    // Global enable stays off until the write has started
    wr(IRQ_OFS, 8'h01);
    wr(SECOND_INDIRECT_PORT_OFS, 8'h08);
    wr(SECOND_INDIRECT_PORT_OFS, 8'h0C);
    wr(IRQ_OFS, 8'h05);
    cmp1("busy", 1'b1, o_nvm_busy);
    rd(SECOND_INDIRECT_PORT_OFS, 8'h0C);
    idle(20);
    cmp1("busy", 1'b1, o_nvm_busy);
    // 63 rising edges, one short of the write length
    lsc(126);
    cmp1("busy", 1'b1, o_nvm_busy);
    i_low_speed_clock = 1'b1;
    idle(3);
    i_low_speed_clock = 1'b0;
    cmp1("busy", 1'b0, o_nvm_busy);
    rd(SECOND_INDIRECT_PORT_OFS, 8'h08);
    rd(IRQ_OFS, 8'h07);
    cmp1("irq", 1'b1, o_store_irq_req);
    i_stack_full = 1'b1;
    idle(1);
    cmp1("irq", 1'b0, o_store_irq_req);
    i_stack_full = 1'b0;
    i_irq_serviced = 1'b1;
    idle(1);
    i_irq_serviced = 1'b0;
    idle(1);
    cmp1("irq", 1'b0, o_store_irq_req);
    rd(IRQ_OFS, 8'h01);
    wr(DATA_OFS, ~d);
    wr(SECOND_INDIRECT_PORT_OFS, 8'h08);
    wr(SECOND_INDIRECT_PORT_OFS, 8'h0C);
    i_cpu_halt = 1'b1;
    idle(2);
    i_cpu_halt = 1'b0;
    cmp1("busy", 1'b0, o_nvm_busy);
    rd(IRQ_OFS, 8'h01);
    rd(SECOND_INDIRECT_PORT_OFS, 8'h08);
    wr(ADDR_OFS, {3'h0, a});
    wr(SECOND_INDIRECT_PORT_OFS, 8'h02);
    wr(SECOND_INDIRECT_PORT_OFS, 8'h03);
    // Second trigger lands while the read runs and must start nothing
    wr(SECOND_INDIRECT_PORT_OFS, 8'h03);
    cmp1("busy", 1'b1, o_nvm_busy);
    idle(2);
    cmp1("busy", 1'b0, o_nvm_busy);
    rd(DATA_OFS, d);
    rd(SECOND_INDIRECT_PORT_OFS, 8'h02);
    wr(ADDR_OFS, {3'h0, ~a});
    rd(DATA_OFS, d);
    wr(SECOND_INDIRECT_PORT_OFS, 8'h00);
    wr(BANK_OFS, 8'h00);
    idle(3);
    results();
  end
endmodule
